// ### design/nand_addr_format.sv
// Address cycle formatter: builds one address byte from column, page and
// block fields. Pure combinational; the caller registers the result.
`timescale 1ns/100ps
module nand_addr_format #(
    parameter bit WIDE = 1'b0
) (
    input wire logic [nand_host_pkg::COLUMN_BITS-1:0] column,
    input wire logic [nand_host_pkg::PAGE_BITS-1:0] page,
    input wire logic [nand_host_pkg::BLOCK_BITS-1:0] block,
    input wire logic [2:0] index,
    output logic [7:0] cycleByte
);
    import nand_host_pkg::*;

    logic [11:0] col;

    ////////////////////////////////////////////////////////////////////////
    // Spare-area column: upper in-page bits forced low so a bad request
    // cannot address past the page end
    always_comb begin
        col = column;
        if (WIDE) begin
            col[11] = 1'b0;
            if (col[10]) begin
                col[9:5] = 5'h00;
            end
        end else begin
            if (col[11]) begin
                col[10:6] = 5'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle layout; row is block above page, unused bits held low
    always_comb begin
        unique case (index)
            3'h0: cycleByte = col[7:0];
            3'h1: cycleByte = WIDE ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
            3'h2: cycleByte = {block[1:0], page};
            3'h3: cycleByte = block[9:2];
            3'h4: cycleByte = {7'h00, block[10]};
            default: cycleByte = 8'h00;
        endcase
    end

endmodule

// ### design/nand_host_port.sv
// Host-side controller for an asynchronous multiplexed NAND bus port.
// Assumes the die pins connect directly; the ready/busy line is pulled up
// externally and data pins are resolved from ioOut/ioOe by the board.
`timescale 1ns/100ps

// What this block does
// - Command cycle: CLE high, ALE low, write strobe pulsed, read high.
// - Address cycle: ALE high, CLE low, write strobe pulsed, read high.
// - Data write cycle: CLE and ALE low, write strobe pulsed.
// - Read cycle is 30ns or longer, so data latches at strobe rise.
// - Commands and addresses on low byte; upper byte zero.
// - Narrow bus: five address cycles; column bit 11 forces bits 10..6 low.
// - Wide bus: second cycle holds column bits 10..8; bit 10 clears 9..5.
// - Bits outside the address fields are driven low.
// - Write-protect changes only when ready, then wait settle time.
// - After 78h issue read mode 00h before reading array data.
module nand_host_port #(
    parameter int BUS_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire nand_host_pkg::op_t reqOp,
    input wire logic [7:0] reqCmd,
    input wire logic [BUS_WIDTH-1:0] reqData,
    input wire logic [nand_host_pkg::COLUMN_BITS-1:0] reqColumn,
    input wire logic [nand_host_pkg::PAGE_BITS-1:0] reqPage,
    input wire logic [nand_host_pkg::BLOCK_BITS-1:0] reqBlock,
    output logic reqAck,
    output logic ctrlIdle,
    output logic [BUS_WIDTH-1:0] rdData,
    output logic rdValid,
    output logic targetBusy,
    output logic wpAbortSeen,
    output logic chipSelect_n,
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobe_n,
    output logic read_strobe_n,
    output logic writeProtect_n,
    input wire logic readyBusy_n,
    input wire logic [BUS_WIDTH-1:0] ioIn,
    output logic [BUS_WIDTH-1:0] ioOut,
    output logic ioOe
);
    import nand_host_pkg::*;

    if (BUS_WIDTH != 8 && BUS_WIDTH != 16) begin : g_bad_width
        $error("BUS_WIDTH must be 8 or 16");
    end
    if (READ_LOW_CYC == 4'h0 || WP_CYC == 4'h0) begin : g_bad_timing
        $error("timing counts must fit four bits");
    end

    localparam bit WIDE = (BUS_WIDTH == 16);

    logic [1:0] rstSync_q;
    logic rstN;
    logic [1:0] rbSync_q;
    logic [BUS_WIDTH-1:0] io1_q;
    logic [BUS_WIDTH-1:0] io2_q;
    logic rbReady;
    state_t state_q;
    logic [3:0] cnt_q;
    logic [2:0] addrIdx_q;
    logic [2:0] cyclesLeft_q;
    op_t curOp_q;
    logic [7:0] curCmd_q;
    logic [BUS_WIDTH-1:0] curData_q;
    logic [COLUMN_BITS-1:0] column_q;
    logic [PAGE_BITS-1:0] page_q;
    logic [BLOCK_BITS-1:0] block_q;
    logic [7:0] lastCmd_q;
    logic [7:0] addrByte;
    logic permitted;
    logic insertReadMode;
    logic isRead;
    logic lastCycle;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; nothing reads the first stage but the second
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rbSync_q <= 2'b00;
            io1_q <= '0;
            io2_q <= '0;
        end else begin
            rbSync_q <= {rbSync_q[0], readyBusy_n};
            io1_q <= ioIn;
            io2_q <= io1_q;
        end
    end
    assign rbReady = rbSync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Address byte for the current address cycle
    nand_addr_format #(
        .WIDE(WIDE)
    ) u_fmt (
        .column(column_q),
        .page(page_q),
        .block(block_q),
        .index(addrIdx_q),
        .cycleByte(addrByte)
    );

    ////////////////////////////////////////////////////////////////////////
    // Admission filter: a busy target only gets what it will accept
    always_comb begin
        permitted = rbReady;
        insertReadMode = 1'b0;
        unique case (reqOp)
            OP_CMD: permitted = rbReady || reqCmd == CMD_STATUS ||
                                reqCmd == CMD_STATUS_ENH;
            OP_ADDR: permitted = rbReady || lastCmd_q == CMD_STATUS_ENH;
            OP_STATUS_READ: permitted = rbReady ||
                                        lastCmd_q == CMD_STATUS ||
                                        lastCmd_q == CMD_STATUS_ENH;
            OP_READ: insertReadMode = lastCmd_q == CMD_STATUS_ENH;
            // writes and protect changes wait for ready
            default: permitted = rbReady;
        endcase
    end

    assign isRead = curOp_q == OP_READ || curOp_q == OP_STATUS_READ;
    assign lastCycle = cyclesLeft_q == 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: setup, strobe low, strobe high per bus cycle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            addrIdx_q <= 3'h0;
            cyclesLeft_q <= 3'h0;
            curOp_q <= OP_CMD;
            curCmd_q <= CMD_NONE;
            curData_q <= '0;
            column_q <= '0;
            page_q <= '0;
            block_q <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (reqValid && permitted) begin
                        curOp_q <= insertReadMode ? OP_CMD : reqOp;
                        curCmd_q <= insertReadMode ? CMD_READ_MODE : reqCmd;
                        curData_q <= reqData;
                        column_q <= reqColumn;
                        page_q <= reqPage;
                        block_q <= reqBlock;
                        addrIdx_q <= 3'h0;
                        cyclesLeft_q <= (reqOp == OP_ADDR && !insertReadMode)
                                        ? ADDR_CYCLES : 3'h1;
                        cnt_q <= WP_CYC - 4'h1;
                        state_q <= (reqOp == OP_WP) ? S_WP : S_SETUP;
                    end
                end
                S_SETUP: begin
                    // One extra low-state edge: it raises the strobe, so
                    // select and latches still stand at the rising edge
                    cnt_q <= isRead ? READ_LOW_CYC : LOW_CYC;
                    state_q <= S_LOW;
                end
                S_LOW: begin
                    if (cnt_q == 4'h0) begin
                        cnt_q <= HIGH_CYC - 4'h1;
                        state_q <= S_HIGH;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                S_HIGH: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (lastCycle) begin
                        state_q <= S_IDLE;
                    end else begin
                        cyclesLeft_q <= cyclesLeft_q - 3'h1;
                        addrIdx_q <= addrIdx_q + 3'h1;
                        state_q <= S_SETUP;
                    end
                end
                S_WP: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus pins; deselect between operations lets the die go to standby
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            chipSelect_n <= 1'b1;
            cmdLatch <= 1'b0;
            addrLatch <= 1'b0;
            writeStrobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            ioOut <= '0;
            ioOe <= 1'b0;
        end else begin
            unique case (state_q)
                S_SETUP: begin
                    chipSelect_n <= 1'b0;
                    cmdLatch <= curOp_q == OP_CMD;
                    addrLatch <= curOp_q == OP_ADDR;
                    ioOe <= !isRead;
                    // upper byte zero for command and address
                    if (curOp_q == OP_CMD) begin
                        ioOut <= BUS_WIDTH'(curCmd_q);
                    end else if (curOp_q == OP_ADDR) begin
                        ioOut <= BUS_WIDTH'(addrByte);
                    end else begin
                        ioOut <= curData_q;
                    end
                end
                S_LOW: begin
                    writeStrobe_n <= isRead || cnt_q == 4'h0;
                    read_strobe_n <= !isRead || cnt_q == 4'h0;
                end
                S_HIGH: begin
                    if (cnt_q == 4'h0) begin
                        chipSelect_n <= lastCycle ? 1'b1 : 1'b0;
                        cmdLatch <= 1'b0;
                        addrLatch <= 1'b0;
                        ioOe <= 1'b0;
                    end
                end
                default: begin
                    chipSelect_n <= 1'b1;
                    writeStrobe_n <= 1'b1;
                    read_strobe_n <= 1'b1;
                    ioOe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture on the strobe rise; low phase covers synchroniser lag
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData <= '0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= state_q == S_LOW && cnt_q == 4'h0 && isRead;
            if (state_q == S_LOW && cnt_q == 4'h0 && isRead) begin
                rdData <= io2_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command history, abort flag and user handshake
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lastCmd_q <= CMD_NONE;
            wpAbortSeen <= 1'b0;
            writeProtect_n <= 1'b0;  // Protected until software opens it
            reqAck <= 1'b0;
            ctrlIdle <= 1'b0;
            targetBusy <= 1'b1;
        end else begin
            reqAck <= state_q == S_IDLE && reqValid && permitted &&
                      !insertReadMode;
            ctrlIdle <= state_q == S_IDLE;
            targetBusy <= !rbReady;
            if (state_q == S_SETUP && curOp_q == OP_CMD) begin
                lastCmd_q <= curCmd_q;
                if (curCmd_q != CMD_STATUS && curCmd_q != CMD_STATUS_ENH) begin
                    wpAbortSeen <= 1'b0;
                end
            end
            // sticky abort status, set wins over clear
            if (state_q == S_LOW && cnt_q == 4'h0 &&
                curOp_q == OP_STATUS_READ &&
                io2_q[7:0] == STATUS_WP_ABORT) begin
                wpAbortSeen <= 1'b1;
            end
            // protect level, changed only when ready
            if (state_q == S_IDLE && reqValid && reqOp == OP_WP && rbReady) begin
                writeProtect_n <= reqData[0];
            end
        end
    end

endmodule

// ### inc/nand_host_pkg.sv
// Constants, opcodes and state codes for the asynchronous NAND host port.
// Assumes a single 25 MHz system clock; every time is turned into cycles.
package nand_host_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command codes the host treats specially
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_READ_MODE = 8'h00;
    localparam logic [7:0] CMD_NONE = 8'hFF;
    // Status value left behind by a write-protect abort
    localparam logic [7:0] STATUS_WP_ABORT = 8'h60;

    ////////////////////////////////////////////////////////////////////////
    // Address layout
    localparam logic [2:0] ADDR_CYCLES = 3'h5;
    localparam int COLUMN_BITS = 12;
    localparam int PAGE_BITS = 6;
    localparam int BLOCK_BITS = 11;  // block bits 16..6

    ////////////////////////////////////////////////////////////////////////
    // Timing, in nanoseconds as printed, and derived cycle counts
    localparam int CLK_MHZ = 25;
    localparam int STROBE_LOW_NS = 40;
    localparam int STROBE_HIGH_NS = 40;
    localparam int WP_SETTLE_NS = 100;  // wp_settle_time, plain default
    localparam int SYNC_STAGES = 2;
    localparam int LOW_CYC_I = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int HIGH_CYC_I = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_CYC_I = (WP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] LOW_CYC = 4'(LOW_CYC_I);
    localparam logic [3:0] READ_LOW_CYC = 4'(LOW_CYC_I + SYNC_STAGES);
    localparam logic [3:0] HIGH_CYC = 4'(HIGH_CYC_I);
    localparam logic [3:0] WP_CYC = 4'(WP_CYC_I);

    ////////////////////////////////////////////////////////////////////////
    // Request opcodes from the user side
    typedef enum logic [2:0] {
        OP_CMD = 3'b000,
        OP_ADDR = 3'b001,
        OP_WRITE = 3'b010,
        OP_READ = 3'b011,
        OP_STATUS_READ = 3'b100,
        OP_WP = 3'b101
    } op_t;

    // Controller states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_LOW = 3'b010,
        S_HIGH = 3'b011,
        S_WP = 3'b100
    } state_t;

endpackage

// ### verification/nand_die_model.sv
// Behavioural model of one NAND die on the asynchronous bus.
// Assumes the bench resolves the shared data lines into ioBus.
`timescale 1ns/100ps
module nand_die_model #(
    parameter int W = 8,
    parameter int BUSY_NS = 4000
) (
    input wire logic chipSelect_n,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobe_n,
    input wire logic read_strobe_n,
    input wire logic writeProtect_n,
    input wire logic [W-1:0] ioBus,
    output logic readyBusy_n,
    output logic [W-1:0] devOut,
    output logic devOe
);
    logic busy = 1'b0;
    logic stMode = 1'b0;
    logic abortQ = 1'b0;
    logic [7:0] lastCmd = 8'hFF;
    logic [7:0] addrB [5];
    logic [W-1:0] cache [64];
    int addrCnt = 0;
    int wPtr = 0;
    int rPtr = 0;
    wire logic [7:0] stat = abortQ ? 8'h60 :
        {writeProtect_n, !busy, !busy, 5'h00};

    assign readyBusy_n = !busy;

    always @(posedge writeStrobe_n) begin
        if (!chipSelect_n && read_strobe_n) begin
            if (cmdLatch && !addrLatch &&
                (!busy || ioBus[7:0] inside {8'h70, 8'h78})) begin
                lastCmd = ioBus[7:0];
                addrCnt = 0;
                stMode = lastCmd inside {8'h70, 8'h78};
                if (!stMode) abortQ = 1'b0;
                // Write pointer runs on across program commands so that
                // every word the bench wrote can be read back in order
                if (lastCmd == 8'h00) rPtr = 0;
                // Protected die never starts program or erase
                if (lastCmd inside {8'h10, 8'hD0} && writeProtect_n)
                    busy = 1'b1;
            end else if (addrLatch && !cmdLatch &&
                (!busy || lastCmd == 8'h78)) begin
                if (addrCnt < 5) addrB[addrCnt] = ioBus[7:0];
                addrCnt++;
            end else if (!cmdLatch && !addrLatch && !busy) begin
                cache[wPtr] = ioBus;
                wPtr++;
            end
        end
    end

    always @(negedge writeProtect_n) begin
        if (busy) begin
            abortQ = 1'b1;
            busy = 1'b0;
        end
    end

    // Array time; a restart during the wait is not modelled
    always @(posedge busy) begin
        #(BUSY_NS);
        busy = 1'b0;
    end

    always @(negedge read_strobe_n) begin
        if (!chipSelect_n && !cmdLatch && !addrLatch && writeStrobe_n) begin
            if (stMode) begin
                devOut = W'(stat);
                devOe = 1'b1;
            end else if (!busy) begin
                devOut = cache[rPtr];
                rPtr++;
                devOe = 1'b1;
            end
        end
    end

    // release; stale data is inverted so it never matches
    always @(posedge read_strobe_n or posedge chipSelect_n) begin
        devOe = 1'b0;
        devOut = ~devOut;
    end

    initial begin
        devOe = 1'b0;
        devOut = '0;
    end
endmodule

// ### verification/nand_host_port_asserts.sv
// Port checker for the NAND host controller.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/100ps
module nand_host_port_asserts
    import nand_host_pkg::*;
#(
    parameter int BUS_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqAck,
    input wire nand_host_pkg::op_t reqOp,
    input wire logic rdValid,
    input wire logic targetBusy,
    input wire logic chipSelect_n,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobe_n,
    input wire logic read_strobe_n,
    input wire logic writeProtect_n,
    input wire logic [BUS_WIDTH-1:0] ioOut,
    input wire logic ioOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////
    // Strobe framing of host-driven cycles
    property p_cmdCycle;
        $rose(writeStrobe_n) && cmdLatch |->
            !chipSelect_n && !addrLatch && read_strobe_n;
    endproperty
    a_cmdCycle: assert property (p_cmdCycle)
        else $error("command strobe outside command framing");
    property p_addrCycle;
        $rose(writeStrobe_n) && addrLatch |->
            !chipSelect_n && !cmdLatch && read_strobe_n;
    endproperty
    a_addrCycle: assert property (p_addrCycle)
        else $error("address strobe outside address framing");
    property p_dataCycle;
        $rose(writeStrobe_n) && !cmdLatch && !addrLatch |->
            !chipSelect_n && read_strobe_n && ioOe;
    endproperty
    a_dataCycle: assert property (p_dataCycle)
        else $error("data strobe without select or drive");
    // Upper byte must be quiet whenever a command or address goes out
    property p_upperZero;
        (cmdLatch || addrLatch) && ioOe |-> (ioOut >> 8) == '0;
    endproperty
    a_upperZero: assert property (p_upperZero)
        else $error("upper byte not zero on command or address");

    ////////////////////////////////////////
    // Read cycles: three low cycles, latch at rise
    property p_readLow;
        $fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n;
    endproperty
    a_readLow: assert property (p_readLow)
        else $error("read strobe low time wrong");
    property p_rdValid;
        rdValid == $rose(read_strobe_n);
    endproperty
    a_rdValid: assert property (p_rdValid)
        else $error("read data not taken at strobe rise");
    // Host must never fight the die while it drives
    property p_readFrame;
        !read_strobe_n |-> !chipSelect_n && !ioOe && !cmdLatch
            && !addrLatch && writeStrobe_n;
    endproperty
    a_readFrame: assert property (p_readFrame)
        else $error("read strobe low with bad framing");

    ////////////////////////////////////////
    // Readiness, settle time and deselect
    // Ack and targetBusy are both registered at the taking edge
    property p_busyGate;
        reqAck && reqOp inside {OP_WRITE, OP_READ, OP_WP} |->
            !targetBusy;
    endproperty
    a_busyGate: assert property (p_busyGate)
        else $error("ready-only request taken while busy");
    property p_wpSettle;
        $changed(writeProtect_n) |-> chipSelect_n [*3];
    endproperty
    a_wpSettle: assert property (p_wpSettle)
        else $error("select asserted inside protect settle time");
    property p_deselect;
        $fell(chipSelect_n) |-> ##[1:40] chipSelect_n;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("select held too long");
endmodule

bind nand_host_port nand_host_port_asserts #(.BUS_WIDTH(BUS_WIDTH)) i_chk (
    .clk, .rst_n, .reqAck, .reqOp, .rdValid, .targetBusy, .chipSelect_n,
    .cmdLatch, .addrLatch, .writeStrobe_n, .read_strobe_n,
    .writeProtect_n, .ioOut, .ioOe);

// ### verification/nand_host_port_test.sv
// Self-checking bench for the NAND host controller.
// Assumes the die model and the bound port checker.
`timescale 1ns/100ps
module nand_host_port_test;
    import nand_host_pkg::*;
    logic clk, rst_n, reqValid, reqAck, ctrlIdle, rdValid, targetBusy;
    logic wpAbortSeen, chipSelect_n, cmdLatch, addrLatch, writeStrobe_n;
    logic read_strobe_n, writeProtect_n, readyBusy_n, ioOe, devOe;
    op_t reqOp;
    logic [7:0] reqCmd, reqData, rdData, ioIn, ioOut, devOut;
    logic [11:0] reqColumn;
    logic [5:0] reqPage;
    logic [10:0] reqBlock;
    logic [31:0] seed = 32'h0000_001D;
    logic [7:0] wd [5];
    int errors = 0;
    int total_checks = 0;

    // Shared lines: host, then die, else a changing stale value
    assign ioIn = ioOe ? ioOut : (devOe ? devOut : ~ioOut);

    nand_host_port #(.BUS_WIDTH(8)) i_dut (.clk, .rst_n, .reqValid,
        .reqOp, .reqCmd, .reqData, .reqColumn, .reqPage, .reqBlock,
        .reqAck, .ctrlIdle, .rdData, .rdValid, .targetBusy, .wpAbortSeen,
        .chipSelect_n, .cmdLatch, .addrLatch, .writeStrobe_n,
        .read_strobe_n, .writeProtect_n, .readyBusy_n, .ioIn, .ioOut,
        .ioOe);
    nand_die_model #(.W(8)) i_die (.chipSelect_n, .cmdLatch, .addrLatch,
        .writeStrobe_n, .read_strobe_n, .writeProtect_n, .ioBus(ioIn),
        .readyBusy_n, .devOut, .devOe);

    ////////////////////////////////////////
    // Clock and helpers
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected address byte; x8 clamp on the high column bit
    function automatic logic [7:0] fmt(input int i);
        logic [11:0] c;
        c = reqColumn;
        if (c[11]) c[10:6] = 5'h00;
        case (i)
            0: return c[7:0];
            1: return {4'h0, c[11:8]};
            2: return {reqBlock[1:0], reqPage};
            3: return reqBlock[9:2];
            default: return {7'h00, reqBlock[10]};
        endcase
    endfunction

    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One request, held until acked, then wait for idle
    task automatic req(input op_t op, input logic [7:0] c,
        input logic [7:0] d);
        int n;
        @(posedge clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqCmd <= c;
        reqData <= d;
        n = 0;
        do begin @(negedge clk); n++; end while (reqAck !== 1'b1 && n < 4000);
        @(posedge clk);
        reqValid <= 1'b0;
        do begin @(negedge clk); n++; end while (ctrlIdle !== 1'b1 && n < 4000);
        if (n >= 4000) check("handshake", 8'h00, 8'h01);
    endtask

    task automatic address(input bit corner);
        @(posedge clk);
        reqColumn <= corner ? 12'hFFF : 12'(rnd());
        reqPage <= 6'(rnd());
        reqBlock <= 11'(rnd());
        req(OP_ADDR, 8'h00, 8'h00);
    endtask

    task automatic program_busy();
        req(OP_CMD, 8'h80, 8'h00);
        address(1'b0);
        req(OP_CMD, 8'h10, 8'h00);
        for (int n = 0; n < 100 && targetBusy !== 1'b1; n++) @(negedge clk);
        check("busy", targetBusy, 8'h01); // busy seen
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqOp = OP_CMD;
        reqCmd = 8'h00;
        reqData = 8'h00;
        reqColumn = 12'h000;
        reqPage = 6'h00;
        reqBlock = 11'h000;
        repeat (2) @(posedge clk);
        check("csReset", chipSelect_n, 8'h01); // deselected
        check("wpReset", writeProtect_n, 8'h00); // protected
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        req(OP_WP, 8'h00, 8'h01);
        check("wpPin", writeProtect_n, 8'h01); // unprotect
        for (int i = 0; i < 4; i++) begin
            req(OP_CMD, 8'h80, 8'h00);
            address(i == 0);
            for (int j = 0; j < 5; j++)
                check("addr", i_die.addrB[j], fmt(j)); // bytes
        end
        for (int j = 0; j < 4; j++) begin
            wd[j] = 8'(rnd());
            req(OP_WRITE, 8'h00, wd[j]);
            check("cache", i_die.cache[j], wd[j]); // data in
        end
        program_busy();
        req(OP_CMD, 8'h70, 8'h00);
        req(OP_STATUS_READ, 8'h00, 8'h00);
        check("busyStat", rdData, 8'h80); // busy status
        wd[4] = 8'h5A;
        req(OP_WRITE, 8'h00, wd[4]);
        req(OP_CMD, 8'h00, 8'h00);
        for (int j = 0; j < 5; j++) begin
            req(OP_READ, 8'h00, 8'h00);
            check("rd", rdData, wd[j]); // read back
        end
        program_busy();
        req(OP_CMD, 8'h78, 8'h00);
        address(1'b0);
        check("addrCnt", 8'(i_die.addrCnt), 8'h05); // busy address
        req(OP_STATUS_READ, 8'h00, 8'h00);
        check("enhStat", rdData, 8'h80); // enhanced status
        req(OP_READ, 8'h00, 8'h00);
        check("mode", i_die.lastCmd, 8'h00); // read mode first
        check("rd78", rdData, wd[0]); // array data
        req(OP_WP, 8'h00, 8'h00);
        req(OP_CMD, 8'h80, 8'h00);
        req(OP_CMD, 8'h10, 8'h00);
        req(OP_CMD, 8'h70, 8'h00);
        req(OP_STATUS_READ, 8'h00, 8'h00);
        check("wpStat", rdData, 8'h60); // refused program
        check("abortSeen", wpAbortSeen, 8'h01); // sticky flag
        req(OP_CMD, 8'hFF, 8'h00);
        check("abortClr", wpAbortSeen, 8'h00); // cleared
        finish_test();
    end

    // Hang guard, well above the expected run length
    initial begin
        #(40 * 20000);
        errors++;
        finish_test();
    end
endmodule
